// File: verilog/spc_top.v
// Reset, motion, user and power control registers with their control outputs.
`include "spc_consts.vh"
`default_nettype none

module spc_top #(
  parameter integer BASE_TICKS = `SPC_BASE_TICKS,
  parameter integer DEVRST_TICKS = `SPC_DEVRST_TICKS
) (
  input wire CLK,
  input wire RST,
  input wire [6:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  input wire [7:0] SAMPLE_DIV,
  input wire STANDBY,
  input wire ACCEL_ALL_STANDBY,
  input wire PLL_READY,
  output reg ACCEL_PATH_RST,
  output reg TEMP_PATH_RST,
  output reg SENSOR_REG_CLEAR,
  output reg MOTION_DETECT_EN,
  output reg MOTION_COMPARE_MODE,
  output reg BUFFER_ENABLE,
  output reg TWO_WIRE_ENABLE,
  output reg BUFFER_RST,
  output reg SLEEP_ACTIVE,
  output reg WAKE_PULSE,
  output reg SAMPLE_PULSE,
  output reg THERMAL_SENSOR_EN,
  output reg CLOCK_FROM_PLL,
  output reg CLOCK_STOPPED,
  output reg DEVICE_RESET_BUSY
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RESETTING = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [3:0] devrst_cnt;
  reg motion_en;
  reg motion_mode;
  reg buf_en;
  reg two_wire_dis;
  reg buf_rst;
  reg buf_rst_seen;
  reg sleep;
  reg cycle;
  reg therm_dis;
  reg [2:0] clk_sel;
  reg [15:0] base_cnt;
  reg [7:0] div_cnt;
  reg [7:0] next_rdata;
  wire osc_tick;
  wire soft_rst;
  wire wr_path;
  wire wr_motion;
  wire wr_user;
  wire wr_power;
  wire cycling;
  wire interval_done;

  // Integer differences are cut to the counter widths on purpose.
  localparam integer BASE_LAST_INT = BASE_TICKS - 1;
  localparam integer DEVRST_LAST_INT = DEVRST_TICKS - 1;
  localparam [15:0] BASE_LAST = BASE_LAST_INT[15:0];
  localparam [3:0] DEVRST_LAST = DEVRST_LAST_INT[3:0];
  localparam [7:0] RST_MOTION = `SPC_RST_MOTION;
  localparam [7:0] RST_POWER1 = `SPC_RST_POWER1;

  assign wr_path = REG_WR && (REG_ADDR == `SPC_ADDR_PATH_RST);
  assign wr_motion = REG_WR && (REG_ADDR == `SPC_ADDR_MOTION);
  assign wr_user = REG_WR && (REG_ADDR == `SPC_ADDR_USER);
  assign wr_power = REG_WR && (REG_ADDR == `SPC_ADDR_POWER1);
  assign soft_rst = (state == ST_RESETTING);

  // ----------------------------------------------------------------------
  // Oscillator-rate enable
  // ----------------------------------------------------------------------
  // The oscillator tick keeps running even when code 7 stops the sample clock,
  // so the self-clearing buffer reset can always complete.
  spc_osc_tick #(
    .CLK_MHZ(`SPC_CLK_MHZ),
    .OSC_MHZ(`SPC_OSC_MHZ)
  ) u_osc_tick (
    .clk(CLK),
    .rst(RST),
    .tick(osc_tick)
  );

  // ----------------------------------------------------------------------
  // Device reset sequencer
  // ----------------------------------------------------------------------
  // Next-state decode for the device reset sequence.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_power && REG_WDATA[`SPC_BIT_DEV_RST]) begin
          next_state = ST_RESETTING;
        end
      end
      ST_RESETTING: begin
        if (osc_tick && (devrst_cnt == DEVRST_LAST)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // The sequence lasts a fixed number of oscillator ticks, then drops the bit.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      devrst_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (!soft_rst) begin
        devrst_cnt <= 4'h0;
      end else if (osc_tick) begin
        devrst_cnt <= devrst_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Stored fields; reserved bits have no storage, so writes to them vanish.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      motion_en <= 1'b0;
      motion_mode <= 1'b0;
      buf_en <= 1'b0;
      two_wire_dis <= 1'b0;
      sleep <= 1'b1;
      cycle <= 1'b0;
      therm_dis <= 1'b0;
      clk_sel <= `SPC_RST_CLOCK_SOURCE_SELECT;
    end else if (soft_rst) begin
      motion_en <= RST_MOTION[`SPC_BIT_MOTION_EN];
      motion_mode <= 1'b0;
      buf_en <= 1'b0;
      two_wire_dis <= 1'b0;
      sleep <= RST_POWER1[`SPC_BIT_SLEEP];
      cycle <= 1'b0;
      therm_dis <= 1'b0;
      clk_sel <= `SPC_RST_CLOCK_SOURCE_SELECT;
    end else begin
      if (wr_motion) begin
        motion_en <= REG_WDATA[`SPC_BIT_MOTION_EN];
        motion_mode <= REG_WDATA[`SPC_BIT_MOTION_MODE];
      end
      if (wr_user) begin
        buf_en <= REG_WDATA[`SPC_BIT_BUF_EN];
        two_wire_dis <= REG_WDATA[`SPC_BIT_TWO_WIRE_DIS];
      end
      if (wr_power) begin
        sleep <= REG_WDATA[`SPC_BIT_SLEEP];
        cycle <= REG_WDATA[`SPC_BIT_CYCLE];
        therm_dis <= REG_WDATA[`SPC_BIT_THERM_DIS];
        clk_sel <= REG_WDATA[`SPC_CLOCK_SOURCE_SELECT_HI:`SPC_CLOCK_SOURCE_SELECT_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Buffer reset bit
  // ----------------------------------------------------------------------
  // The bit must span a full oscillator period, so it waits for one tick to
  // pass after the write before clearing; a new write in that cycle wins.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      buf_rst <= 1'b0;
      buf_rst_seen <= 1'b0;
    end else if (wr_user && REG_WDATA[`SPC_BIT_BUF_RST]) begin
      buf_rst <= 1'b1;
      buf_rst_seen <= 1'b0;
    end else if (soft_rst) begin
      buf_rst <= 1'b0;
      buf_rst_seen <= 1'b0;
    end else if (buf_rst && osc_tick) begin
      buf_rst_seen <= 1'b1;
      if (buf_rst_seen) begin
        buf_rst <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Signal-path reset pulses
  // ----------------------------------------------------------------------
  // One-cycle pulses; only the full conditioning reset clears the outputs.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      ACCEL_PATH_RST <= 1'b0;
      TEMP_PATH_RST <= 1'b0;
      SENSOR_REG_CLEAR <= 1'b0;
    end else begin
      ACCEL_PATH_RST <= (wr_path && REG_WDATA[`SPC_BIT_ACCEL_RST])
        || (wr_user && REG_WDATA[`SPC_BIT_COND_RST]);
      TEMP_PATH_RST <= (wr_path && REG_WDATA[`SPC_BIT_TEMP_RST])
        || (wr_user && REG_WDATA[`SPC_BIT_COND_RST]);
      SENSOR_REG_CLEAR <= wr_user && REG_WDATA[`SPC_BIT_COND_RST];
    end
  end

  // ----------------------------------------------------------------------
  // Duty-cycled sampling timer
  // ----------------------------------------------------------------------
  // The interval is BASE_TICKS oscillator ticks times one plus the divider.
  assign cycling = cycle && !sleep && !STANDBY && (clk_sel != `SPC_CLOCK_SOURCE_SELECT_STOP);
  assign interval_done = osc_tick && (base_cnt == BASE_LAST) && (div_cnt == SAMPLE_DIV);

  // Code 7 holds the timing generator, and so this timer, in reset.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      base_cnt <= 16'h0000;
      div_cnt <= 8'h00;
      WAKE_PULSE <= 1'b0;
      SAMPLE_PULSE <= 1'b0;
    end else if (!cycling || soft_rst) begin
      base_cnt <= 16'h0000;
      div_cnt <= 8'h00;
      WAKE_PULSE <= 1'b0;
      SAMPLE_PULSE <= 1'b0;
    end else begin
      WAKE_PULSE <= interval_done;
      SAMPLE_PULSE <= interval_done && !ACCEL_ALL_STANDBY;
      if (osc_tick) begin
        if (base_cnt == BASE_LAST) begin
          base_cnt <= 16'h0000;
          div_cnt <= (div_cnt == SAMPLE_DIV) ? 8'h00 : div_cnt + 8'h01;
        end else begin
          base_cnt <= base_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered control outputs
  // ----------------------------------------------------------------------
  // Every control output is a flop so downstream logic sees clean levels.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      MOTION_DETECT_EN <= 1'b0;
      MOTION_COMPARE_MODE <= 1'b0;
      BUFFER_ENABLE <= 1'b0;
      TWO_WIRE_ENABLE <= 1'b1;
      BUFFER_RST <= 1'b0;
      SLEEP_ACTIVE <= 1'b1;
      THERMAL_SENSOR_EN <= 1'b1;
      CLOCK_FROM_PLL <= 1'b0;
      CLOCK_STOPPED <= 1'b0;
      DEVICE_RESET_BUSY <= 1'b0;
    end else begin
      MOTION_DETECT_EN <= motion_en;
      MOTION_COMPARE_MODE <= motion_mode;
      BUFFER_ENABLE <= buf_en;
      TWO_WIRE_ENABLE <= !two_wire_dis;
      BUFFER_RST <= buf_rst;
      // Between cycled samples the device sleeps as well.
      SLEEP_ACTIVE <= sleep || (cycling && !interval_done);
      THERMAL_SENSOR_EN <= !therm_dis;
      // Codes 0 and 6 stay on the oscillator; PLL only once it reports ready.
      CLOCK_FROM_PLL <= (clk_sel >= `SPC_CLOCK_SOURCE_SELECT_AUTO_LO)
        && (clk_sel <= `SPC_CLOCK_SOURCE_SELECT_AUTO_HI) && PLL_READY;
      CLOCK_STOPPED <= (clk_sel == `SPC_CLOCK_SOURCE_SELECT_STOP);
      DEVICE_RESET_BUSY <= soft_rst;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Read mux; reserved bits and unmapped offsets return zero.
  always @* begin
    next_rdata = 8'h00;
    case (REG_ADDR)
      `SPC_ADDR_PATH_RST: next_rdata = 8'h00;
      `SPC_ADDR_MOTION: begin
        next_rdata[`SPC_BIT_MOTION_EN] = motion_en;
        next_rdata[`SPC_BIT_MOTION_MODE] = motion_mode;
      end
      `SPC_ADDR_USER: begin
        next_rdata[`SPC_BIT_BUF_EN] = buf_en;
        next_rdata[`SPC_BIT_TWO_WIRE_DIS] = two_wire_dis;
        next_rdata[`SPC_BIT_BUF_RST] = buf_rst;
      end
      `SPC_ADDR_POWER1: begin
        next_rdata[`SPC_BIT_DEV_RST] = soft_rst;
        next_rdata[`SPC_BIT_SLEEP] = sleep;
        next_rdata[`SPC_BIT_CYCLE] = cycle;
        next_rdata[`SPC_BIT_THERM_DIS] = therm_dis;
        next_rdata[`SPC_CLOCK_SOURCE_SELECT_HI:`SPC_CLOCK_SOURCE_SELECT_LO] = clk_sel;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is presented one cycle after the strobe.
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end
endmodule // spc_top

`default_nettype wire

// File: verilog/spc_consts.vh
// Constants for the sensor reset and power control register group.
//
// Operation
// - Writing 1 to signal-path-reset bit 1 resets the acceleration path, outputs kept.
// - Writing 1 to signal-path-reset bit 0 resets the temperature path, outputs kept.
// - Motion-control bit 7 set enables the wake-on-motion detection logic.
// - Compare mode 1 compares each sample with the previous; software never writes 0.
// - User-control bit 6 enables the buffer; at 0 serial buffer access is blocked.
// - User-control bit 4 switches off the two-wire slave, leaving SPI only.
// - User-control bit 2 resets the buffer and self-clears after one 20 MHz cycle.
// - User-control bit 0 resets both paths and clears every sensor output register.
// - Power-control bit 7 restores all register defaults, then clears itself.
// - Power-control bit 6 holds the device asleep and resets to 1.
// - Cycle bit with no sleep or standby alternates sleep and one sample per interval.
// - Cycling with every axis in standby still wakes on time but samples nothing.
// - Power-control bit 3 disables the on-chip temperature sensor.
// - Clock-source codes 0 and 6 select the internal 20 MHz oscillator.
// - Codes 1 to 5 run from the PLL when ready, else from the oscillator.
// - Code 7 stops the clock and holds the timing generator in reset.
// - The clock-source field resets to 000, the internal oscillator.
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPC_ADDR_PATH_RST 7'h68
`define SPC_ADDR_MOTION 7'h69
`define SPC_ADDR_USER 7'h6A
`define SPC_ADDR_POWER1 7'h6B

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPC_BIT_ACCEL_RST 1
`define SPC_BIT_TEMP_RST 0
`define SPC_BIT_MOTION_EN 7
`define SPC_BIT_MOTION_MODE 6
`define SPC_BIT_BUF_EN 6
`define SPC_BIT_TWO_WIRE_DIS 4
`define SPC_BIT_BUF_RST 2
`define SPC_BIT_COND_RST 0
`define SPC_BIT_DEV_RST 7
`define SPC_BIT_SLEEP 6
`define SPC_BIT_CYCLE 5
`define SPC_BIT_THERM_DIS 3
`define SPC_CLOCK_SOURCE_SELECT_HI 2
`define SPC_CLOCK_SOURCE_SELECT_LO 0

// ----------------------------------------------------------------------
// Reset values and clock-source codes
// ----------------------------------------------------------------------
`define SPC_RST_MOTION 8'h00
`define SPC_RST_USER 8'h00
`define SPC_RST_POWER1 8'h40
`define SPC_RST_CLOCK_SOURCE_SELECT 3'h0
`define SPC_CLOCK_SOURCE_SELECT_OSC_A 3'h0
`define SPC_CLOCK_SOURCE_SELECT_OSC_B 3'h6
`define SPC_CLOCK_SOURCE_SELECT_AUTO_LO 3'h1
`define SPC_CLOCK_SOURCE_SELECT_AUTO_HI 3'h5
`define SPC_CLOCK_SOURCE_SELECT_STOP 3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPC_CLK_MHZ 250
`define SPC_OSC_MHZ 20
`define SPC_DEVRST_TICKS 4
`define SPC_BASE_TICKS 20000

`endif

// File: verilog/spc_osc_tick.v
// Fractional divider making a one-cycle enable at the internal oscillator rate.
`default_nettype none

module spc_osc_tick #(
  parameter integer CLK_MHZ = 250,
  parameter integer OSC_MHZ = 20
) (
  input wire clk,
  input wire rst,
  output reg tick
);
  // ----------------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------------
  // Both rates fit in nine bits, so the integer values are cut on purpose.
  localparam [8:0] STEP = OSC_MHZ[8:0];
  localparam [8:0] WRAP = CLK_MHZ[8:0];

  reg [8:0] phase;
  wire [8:0] next_phase = phase + STEP;

  // The ratio is not whole, so ticks are spaced 12 or 13 cycles and average 20 MHz.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 9'h000;
      tick <= 1'b0;
    end else if (next_phase >= WRAP) begin
      phase <= next_phase - WRAP;
      tick <= 1'b1;
    end else begin
      phase <= next_phase;
      tick <= 1'b0;
    end
  end
endmodule // spc_osc_tick

`default_nettype wire

// File: verif/spc_chk.sv
// Concurrent checks on the control register group ports.
`default_nettype none
module spc_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic PLL_READY,
  input wire logic ACCEL_ALL_STANDBY,
  input wire logic ACCEL_PATH_RST,
  input wire logic TEMP_PATH_RST,
  input wire logic SENSOR_REG_CLEAR,
  input wire logic BUFFER_RST,
  input wire logic SLEEP_ACTIVE,
  input wire logic TWO_WIRE_ENABLE,
  input wire logic MOTION_DETECT_EN,
  input wire logic THERMAL_SENSOR_EN,
  input wire logic WAKE_PULSE,
  input wire logic SAMPLE_PULSE,
  input wire logic CLOCK_FROM_PLL,
  input wire logic CLOCK_STOPPED,
  input wire logic DEVICE_RESET_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Stored fields other than the buffer reset bit ignore writes while the soft reset runs; the path reset pulses do not, but those cycles are excluded.
  property p_accel;
    REG_WR && REG_ADDR == 7'h68 && REG_WDATA[1] && !DEVICE_RESET_BUSY |-> ##[1:2] ACCEL_PATH_RST;
  endproperty
  a_accel: assert property (p_accel) else $error("accel reset pulse missing");
  property p_temp;
    REG_WR && REG_ADDR == 7'h68 && REG_WDATA[0] && !DEVICE_RESET_BUSY |-> ##[1:2] TEMP_PATH_RST;
  endproperty
  a_temp: assert property (p_temp) else $error("temp reset pulse missing");
  property p_cond;
    REG_WR && REG_ADDR == 7'h6A && REG_WDATA[0] && !DEVICE_RESET_BUSY
      |-> ##[1:2] (SENSOR_REG_CLEAR && ACCEL_PATH_RST && TEMP_PATH_RST);
  endproperty
  a_cond: assert property (p_cond) else $error("conditioning reset incomplete");
  // The output clear must never come without both path resets.
  property p_clr_only;
    SENSOR_REG_CLEAR |-> ACCEL_PATH_RST && TEMP_PATH_RST;
  endproperty
  a_clr_only: assert property (p_clr_only) else $error("clear without both resets");
  property p_bufrst;
    $rose(BUFFER_RST) |-> ##[1:40] !BUFFER_RST;
  endproperty
  a_bufrst: assert property (p_bufrst) else $error("buffer reset never cleared");
  property p_devrst;
    $rose(DEVICE_RESET_BUSY) |-> ##[1:120] !DEVICE_RESET_BUSY;
  endproperty
  a_devrst: assert property (p_devrst) else $error("device reset never ended");
  property p_defaults;
    $fell(DEVICE_RESET_BUSY) |-> SLEEP_ACTIVE && TWO_WIRE_ENABLE && THERMAL_SENSOR_EN
      && !MOTION_DETECT_EN && !CLOCK_FROM_PLL;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not restored");
  property p_pll;
    CLOCK_FROM_PLL |-> $past(PLL_READY);
  endproperty
  a_pll: assert property (p_pll) else $error("pll used while not ready");
  property p_stop;
    CLOCK_STOPPED |-> !CLOCK_FROM_PLL && !WAKE_PULSE;
  endproperty
  a_stop: assert property (p_stop) else $error("activity with clock stopped");
  property p_sample;
    SAMPLE_PULSE |-> WAKE_PULSE && !$past(ACCEL_ALL_STANDBY);
  endproperty
  a_sample: assert property (p_sample) else $error("sample outside a wake");
  c_buf: cover property ($rose(BUFFER_RST));
  c_wake: cover property (WAKE_PULSE && !SAMPLE_PULSE);
  c_dev: cover property ($fell(DEVICE_RESET_BUSY));
endmodule // spc_chk
`default_nettype wire

// File: verif/spc_top_tb_top.sv
// Self-checking testbench for the control register group.
`default_nettype none
module spc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, STANDBY = 0, PLL_READY = 0;
  logic ACCEL_ALL_STANDBY = 0;
  logic [6:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0, SAMPLE_DIV = 0, d;
  logic [7:0] REG_RDATA;
  logic REG_RVALID, ACCEL_PATH_RST, TEMP_PATH_RST, SENSOR_REG_CLEAR, MOTION_DETECT_EN;
  logic MOTION_COMPARE_MODE, BUFFER_ENABLE, TWO_WIRE_ENABLE, BUFFER_RST, SLEEP_ACTIVE;
  logic WAKE_PULSE, SAMPLE_PULSE, THERMAL_SENSOR_EN, CLOCK_FROM_PLL, CLOCK_STOPPED;
  logic DEVICE_RESET_BUSY;
  logic [7:0] expq[$];
  int n_fail = 0, comparisons = 0, i, t, n, w;
  // Short interval and soft reset counts keep the run brief.
  spc_top #(.BASE_TICKS(4), .DEVRST_TICKS(2)) spc_top_i (
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .SAMPLE_DIV(SAMPLE_DIV), .STANDBY(STANDBY), .ACCEL_ALL_STANDBY(ACCEL_ALL_STANDBY),
    .PLL_READY(PLL_READY), .ACCEL_PATH_RST(ACCEL_PATH_RST), .TEMP_PATH_RST(TEMP_PATH_RST),
    .SENSOR_REG_CLEAR(SENSOR_REG_CLEAR), .MOTION_DETECT_EN(MOTION_DETECT_EN),
    .MOTION_COMPARE_MODE(MOTION_COMPARE_MODE), .BUFFER_ENABLE(BUFFER_ENABLE),
    .TWO_WIRE_ENABLE(TWO_WIRE_ENABLE), .BUFFER_RST(BUFFER_RST), .SLEEP_ACTIVE(SLEEP_ACTIVE),
    .WAKE_PULSE(WAKE_PULSE), .SAMPLE_PULSE(SAMPLE_PULSE),
    .THERMAL_SENSOR_EN(THERMAL_SENSOR_EN), .CLOCK_FROM_PLL(CLOCK_FROM_PLL),
    .CLOCK_STOPPED(CLOCK_STOPPED), .DEVICE_RESET_BUSY(DEVICE_RESET_BUSY));
  // ------------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = v;
    REG_WR = 1;
    @(negedge CLK);
    REG_WR = 0;
  endtask
  // The expected byte is queued as the strobe goes out.
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1;
    expq.push_back(e);
    @(negedge CLK);
    REG_RD = 0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Clock at 4 ns period.
  initial begin
    forever #2 CLK = ~CLK;
  end
  // Read monitor takes the oldest note for every valid strobe.
  always @(posedge CLK) begin
    if (REG_RVALID === 1'b1) begin
      if (expq.size() == 0) chk("spare rvalid", 0, 1);
      else chk("rdata", expq.pop_front(), REG_RDATA);
    end
  end
  // Watchdog sized well above the expected run length.
  initial begin
    #150000;
    n_fail++;
    summarize();
  end
  // Main sequence.
  initial begin
    w = $urandom(32'hd8049543);
    repeat (20) @(negedge CLK);
    RST = 0;
    wr(7'h6C, 8'hFF);
    for (i = 0; i < 5; i++) rd(7'h68 + i, (i == 3) ? 8'h40 : 8'h00);
    chk("sleep", 1, SLEEP_ACTIVE);
    chk("two wire", 1, TWO_WIRE_ENABLE);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom) | 8'h40;
      wr(7'h69, d);
      rd(7'h69, d & 8'hC0);
      chk("motion en", d[7], MOTION_DETECT_EN);
      chk("compare", d[6], MOTION_COMPARE_MODE);
      d = $urandom & 8'hFA;
      wr(7'h6A, d);
      rd(7'h6A, d & 8'h50);
      chk("buf en", d[6], BUFFER_ENABLE);
      chk("two wire", !d[4], TWO_WIRE_ENABLE);
    end
    $display("test control fields done");
    // Every clock-source code with a random PLL state.
    for (i = 0; i < 8; i++) begin
      PLL_READY = $urandom % 2;
      d = 8'h40 | (($urandom % 2) << 3) | i;
      wr(7'h6B, d);
      rd(7'h6B, d);
      chk("pll", (i >= 1 && i <= 5) && PLL_READY, CLOCK_FROM_PLL);
      chk("stopped", i == 7, CLOCK_STOPPED);
      chk("thermal", !d[3], THERMAL_SENSOR_EN);
    end
    $display("test clock source done");
    wr(7'h68, 8'hFF);
    chk("accel rst", 1, ACCEL_PATH_RST);
    chk("temp rst", 1, TEMP_PATH_RST);
    chk("outputs kept", 0, SENSOR_REG_CLEAR);
    rd(7'h68, 8'h00);
    wr(7'h6A, 8'h01);
    chk("cond accel", 1, ACCEL_PATH_RST);
    chk("cond temp", 1, TEMP_PATH_RST);
    chk("cond clear", 1, SENSOR_REG_CLEAR);
    rd(7'h6A, 8'h00);
    wr(7'h6A, 8'h04);
    rd(7'h6A, 8'h04);
    for (t = 0; BUFFER_RST === 1'b1 && t < 60; t++) @(negedge CLK);
    chk("bufrst clear", 1, t < 40);
    rd(7'h6A, 8'h00);
    $display("test resets done");
    // Cycling: wake spacing, sample gating under axis standby, chip standby.
    SAMPLE_DIV = $urandom_range(2, 0);
    n = 4 * (SAMPLE_DIV + 1);
    wr(7'h6B, 8'h20);
    for (i = 0; i < 4; i++) begin
      ACCEL_ALL_STANDBY = i[1];
      @(negedge CLK);
      for (t = 0; WAKE_PULSE !== 1'b1 && t < 2000; t++) @(negedge CLK);
      chk("wake", 1, WAKE_PULSE);
      chk("awake", 0, SLEEP_ACTIVE);
      chk("sample", !i[1], SAMPLE_PULSE);
      if (i[0]) chk("wake gap", 1, t >= 12 * n - 2 && t <= 13 * n);
    end
    STANDBY = 1;
    w = 0;
    repeat (20 * n) begin
      @(negedge CLK);
      w += (WAKE_PULSE === 1'b1);
    end
    chk("standby wakes", 0, w);
    STANDBY = 0;
    $display("test cycling done");
    wr(7'h69, 8'hC0);
    wr(7'h6B, 8'h80);
    wr(7'h69, 8'hC0);
    chk("busy", 1, DEVICE_RESET_BUSY);
    for (t = 0; DEVICE_RESET_BUSY !== 1'b0 && t < 200; t++) @(negedge CLK);
    chk("devrst end", 1, t < 200);
    rd(7'h69, 8'h00);
    rd(7'h6B, 8'h40);
    chk("sleep", 1, SLEEP_ACTIVE);
    repeat (4) @(negedge CLK);
    chk("queue", 0, expq.size());
    $display("test device reset done");
    summarize();
  end
endmodule // spc_top_tb_top
bind spc_top spc_chk spc_chk_i (
  .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .PLL_READY(PLL_READY), .ACCEL_ALL_STANDBY(ACCEL_ALL_STANDBY),
  .ACCEL_PATH_RST(ACCEL_PATH_RST), .TEMP_PATH_RST(TEMP_PATH_RST),
  .SENSOR_REG_CLEAR(SENSOR_REG_CLEAR), .BUFFER_RST(BUFFER_RST), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .TWO_WIRE_ENABLE(TWO_WIRE_ENABLE), .MOTION_DETECT_EN(MOTION_DETECT_EN),
  .THERMAL_SENSOR_EN(THERMAL_SENSOR_EN), .WAKE_PULSE(WAKE_PULSE),
  .SAMPLE_PULSE(SAMPLE_PULSE), .CLOCK_FROM_PLL(CLOCK_FROM_PLL),
  .CLOCK_STOPPED(CLOCK_STOPPED), .DEVICE_RESET_BUSY(DEVICE_RESET_BUSY));
`default_nettype wire
